// file: core/drc_top.sv
// top: range selection, supply band check and calibrated dac code
// ==========================================
// How it works
// - outside clear, the active range comes from the range config bit.
// - in clear, the active range comes from clear_span_select instead.
// - range 0 is the full range and 1 the narrow 4-20 mA range.
// - the supply is classed as low band, high band or invalid.
// - leaving the configured band raises an alarm and applies alarm_response_reg.
// - the internal code is the calibrated data, held in 0 to 2^N-1.
// - output millivolts are code/2^N times full_scale_span plus the range minimum.
// - clear forces the clear range, and clear_value_reg unless a hold, low or high alarm response applies; no data write.
// - the code is data times gain plus signed offset, saturating.
module drc_top
	import drc_pkg::*;
#(
	parameter int N = drc_pkg::DRC_CODE_W_DEF
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// configuration
	input  wire logic             range_sel,
	input  wire logic             clear_span_select,
	input  wire logic             force_clear_bit,
	input  wire logic [N-1:0]     data_in,
	input  wire logic [N-1:0]     gain_in,
	input  wire logic [N-1:0]     offset_in,
	input  wire logic [N-1:0]     clear_value_reg,
	input  wire logic [1:0]       alarm_response_reg,
	// supply monitor, millivolts
	input  wire logic [12:0]      main_supply,
	input  wire logic             band_cfg_high,
	// status and outputs
	output logic                  active_range,
	output logic                  in_clear,
	output drc_pkg::drc_band_t    supply_band,
	output logic                  supply_alarm,
	output logic [N-1:0]          dac_code,
	output logic [12:0]           full_scale_span,
	output logic [12:0]           range_min,
	output logic [12:0]           analog_output
);
	import drc_pkg::*;

	// ==========================================
	// reset release
	logic rst_s1_ff, rst_s2_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// ==========================================
	// calibration
	logic [N-1:0] cal_code;
	drc_calib #(.N(N)) u_calib (
		.data_in   (data_in),
		.gain_in   (gain_in),
		.offset_in (offset_in),
		.code_out  (cal_code)
	);

	// ==========================================
	// band decode, used for live and alarm checks
	function automatic drc_band_t classify(input logic [12:0] mv);
		if (mv >= DRC_LOW_MIN_MV && mv <= DRC_LOW_MAX_MV) begin
			classify = DRC_BAND_LOW;
		end else if (mv >= DRC_HIGH_MIN_MV && mv <= DRC_HIGH_MAX_MV) begin
			classify = DRC_BAND_HIGH;
		end else begin
			classify = DRC_BAND_INVALID;
		end
	endfunction : classify

	// ==========================================
	// state
	logic            range_ff,  nxt_range;
	logic            clear_ff,  nxt_clear;
	drc_band_t       band_ff,   nxt_band;
	logic            alarm_ff,  nxt_alarm;
	logic [N-1:0]    code_ff,   nxt_code;
	logic [12:0]     span_ff,   nxt_span;
	logic [12:0]     min_ff,    nxt_min;
	logic [12:0]     analog_output_ff,   nxt_analog_output;
	logic [N+12:0]   scaled;
	logic            alarm_clear;

	always_comb begin
		nxt_band  = classify(main_supply);
		// alarm when supply is not in the band the part is set up for
		nxt_alarm = band_cfg_high ? (nxt_band != DRC_BAND_HIGH)
		                          : (nxt_band != DRC_BAND_LOW);
		alarm_clear = nxt_alarm && (alarm_response_reg == DRC_ACT_CLEAR);
		nxt_clear = force_clear_bit || alarm_clear;
		// range and code switch in the same cycle as clear
		nxt_range = nxt_clear ? clear_span_select : range_sel;
		if (nxt_alarm && alarm_response_reg == DRC_ACT_LOW) begin
			nxt_code = '0;
		end else if (nxt_alarm && alarm_response_reg == DRC_ACT_HIGH) begin
			nxt_code = '1;
		end else if (nxt_alarm && alarm_response_reg == DRC_ACT_HOLD) begin
			nxt_code = code_ff;
		end else if (nxt_clear) begin
			nxt_code = clear_value_reg;
		end else begin
			nxt_code = cal_code;
		end
		// table of span and minimum, chosen by band_cfg_high and the range; the measured supply band is not used
		case ({band_cfg_high, nxt_range})
			2'b00:   begin nxt_span = DRC_SPAN_LF_MV; nxt_min = DRC_MIN_LF_MV; end
			2'b01:   begin nxt_span = DRC_SPAN_LN_MV; nxt_min = DRC_MIN_LN_MV; end
			2'b10:   begin nxt_span = DRC_SPAN_HF_MV; nxt_min = DRC_MIN_HF_MV; end
			default: begin nxt_span = DRC_SPAN_HN_MV; nxt_min = DRC_MIN_HN_MV; end
		endcase
		// voltage follows registered code and span, one cycle behind
		scaled   = (N+13)'(code_ff) * (N+13)'(span_ff);
		nxt_analog_output = 13'(scaled >> N) + min_ff;
	end

	always_ff @(posedge core_clk or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			range_ff <= DRC_RANGE_RST;
			clear_ff <= 1'b0;
			band_ff  <= DRC_BAND_INVALID;
			alarm_ff <= 1'b0;
			code_ff  <= '0;
			span_ff  <= DRC_SPAN_LF_MV;
			min_ff   <= DRC_MIN_LF_MV;
			analog_output_ff  <= DRC_MIN_LF_MV;
		end else begin
			range_ff <= nxt_range;
			clear_ff <= nxt_clear;
			band_ff  <= nxt_band;
			alarm_ff <= nxt_alarm;
			code_ff  <= nxt_code;
			span_ff  <= nxt_span;
			min_ff   <= nxt_min;
			analog_output_ff  <= nxt_analog_output;
		end
	end

	assign active_range    = range_ff;
	assign in_clear        = clear_ff;
	assign supply_band     = band_ff;
	assign supply_alarm    = alarm_ff;
	assign dac_code        = code_ff;
	assign full_scale_span = span_ff;
	assign range_min       = min_ff;
	assign analog_output   = analog_output_ff;
endmodule : drc_top

// file: core/drc_pkg.sv
// package: constants and types for the dac range and code control block
package drc_pkg;
	// ==========================================
	// widths and reset values
	localparam int          DRC_CODE_W_DEF  = 16;
	localparam logic        DRC_RANGE_FULL  = 1'b0;
	localparam logic        DRC_RANGE_NARROW = 1'b1;
	localparam logic        DRC_RANGE_RST   = 1'b0;
	// ==========================================
	// supply thresholds in millivolts
	localparam logic [12:0] DRC_LOW_MIN_MV  = 13'h06AE; // 1710
	localparam logic [12:0] DRC_LOW_MAX_MV  = 13'h0762; // 1890
	localparam logic [12:0] DRC_HIGH_MIN_MV = 13'h0A8C; // 2700
	localparam logic [12:0] DRC_HIGH_MAX_MV = 13'h157C; // 5500
	// ==========================================
	// span and minimum in millivolts per band and range
	localparam logic [12:0] DRC_SPAN_LF_MV  = 13'h044C; // 1100
	localparam logic [12:0] DRC_MIN_LF_MV   = 13'h0096; // 150
	localparam logic [12:0] DRC_SPAN_LN_MV  = 13'h0320; // 800
	localparam logic [12:0] DRC_MIN_LN_MV   = 13'h00C8; // 200
	localparam logic [12:0] DRC_SPAN_HF_MV  = 13'h0898; // 2200
	localparam logic [12:0] DRC_MIN_HF_MV   = 13'h012C; // 300
	localparam logic [12:0] DRC_SPAN_HN_MV  = 13'h0640; // 1600
	localparam logic [12:0] DRC_MIN_HN_MV   = 13'h0190; // 400
	// ==========================================
	// alarm responses
	localparam logic [1:0]  DRC_ACT_HOLD    = 2'h0;
	localparam logic [1:0]  DRC_ACT_LOW     = 2'h1;
	localparam logic [1:0]  DRC_ACT_HIGH    = 2'h2;
	localparam logic [1:0]  DRC_ACT_CLEAR   = 2'h3;
	// ==========================================
	// supply band
	typedef enum logic [2:0] {
		DRC_BAND_INVALID = 3'b001,
		DRC_BAND_LOW     = 3'b010,
		DRC_BAND_HIGH    = 3'b100
	} drc_band_t;
endpackage : drc_pkg

// file: core/drc_calib.sv
// calibration multiplier: data times gain plus signed offset
module drc_calib #(
	parameter int N = 16
) (
	// operands
	input  wire logic [N-1:0] data_in,
	input  wire logic [N-1:0] gain_in,
	input  wire logic [N-1:0] offset_in,
	// result
	output logic      [N-1:0] code_out
);
	// ==========================================
	// arithmetic
	logic [2*N:0]     prod;
	logic signed [N+2:0] sum;
	logic [N:0]       gain_full;

	always_comb begin
		// gain = 1/2 + g/2^N, so data*(2^(N-1)+g) >> N, low bits dropped
		gain_full = {1'b0, gain_in} + (N+1)'(1 << (N-1));
		prod      = (2*N+1)'(data_in) * (2*N+1)'(gain_full);
		// keep bit 2N: gain above one pushes the product past 2^(2N)
		sum       = $signed({2'b00, prod[2*N:N]})
		          + $signed({{3{offset_in[N-1]}}, offset_in});
		// saturate into 0 .. 2^N-1
		if (sum < 0) begin
			code_out = '0;
		end else if (sum[N+2:N] != 3'b000) begin
			code_out = '1;
		end else begin
			code_out = sum[N-1:0];
		end
	end
endmodule : drc_calib

// file: tb/drc_host.sv
// host model: holds the configuration word that the host last wrote
module drc_host #(
	parameter int W = 8
) (
	// clock, reset and write
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         wr,
	input  wire logic [W-1:0] wr_cfg,
	// configuration as seen by the block
	output logic      [W-1:0] cfg_ff
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) cfg_ff <= '0;
		else if (wr) cfg_ff <= wr_cfg;
	end
endmodule : drc_host

// file: tb/drc_top_monitor.sv
// checker: port relations of the range and code control top
module drc_mon
	import drc_pkg::*;
#(
	parameter int N = 16
) (
	// inputs of the block
	input wire logic core_clk, rst_n, range_sel, clear_span_select, force_clear_bit,
	input wire logic [N-1:0] data_in, gain_in, offset_in, clear_value_reg,
	input wire logic [1:0] alarm_response_reg,
	input wire logic [12:0] main_supply,
	input wire logic band_cfg_high,
	// outputs of the block
	input wire logic active_range, in_clear, supply_alarm,
	input wire drc_pkg::drc_band_t supply_band,
	input wire logic [N-1:0] dac_code,
	input wire logic [12:0] full_scale_span, range_min, analog_output
);
	// ==========================================
	// helpers: outputs only track after the synchroniser has let go
	logic [2:0] up_ff, nxt_up;
	logic lo, hi, bad;
	assign nxt_up = up_ff + 3'(up_ff != 3'h5);
	assign lo = main_supply >= DRC_LOW_MIN_MV && main_supply <= DRC_LOW_MAX_MV;
	assign hi = main_supply >= DRC_HIGH_MIN_MV && main_supply <= DRC_HIGH_MAX_MV;
	assign bad = band_cfg_high ? !hi : !lo;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) up_ff <= 3'h0;
		else up_ff <= nxt_up;
	end
	function automatic logic [N-1:0] cal(input logic [N-1:0] d, g, o);
		longint p;
		p = ((longint'(d) * (longint'(g) + (64'sh1 <<< (N-1)))) >>> N) + longint'($signed(o));
		return (p < 0) ? '0 : (p > (64'sh1 <<< N) - 1) ? '1 : p[N-1:0];
	endfunction : cal
	default clocking @(posedge core_clk); endclocking
	default disable iff (up_ff != 3'h5);
	// ==========================================
	// properties
	rng_norm_a: assert property (!in_clear |-> active_range == $past(range_sel))
		else $error("range not taken from config bit");
	rng_clear_a: assert property (in_clear |-> active_range == $past(clear_span_select))
		else $error("range not taken from clear range bit");
	band_class_a: assert property (supply_band ==
		($past(hi) ? DRC_BAND_HIGH : $past(lo) ? DRC_BAND_LOW : DRC_BAND_INVALID))
		else $error("supply band wrong");
	alarm_flag_a: assert property (supply_alarm == $past(bad))
		else $error("supply alarm wrong");
	act_low_a: assert property ($past(bad && alarm_response_reg == DRC_ACT_LOW) |-> dac_code == '0)
		else $error("alarm zero code missing");
	clear_code_a: assert property ($past(force_clear_bit && !bad) |-> in_clear
		&& dac_code == $past(clear_value_reg)) else $error("clear code not forced");
	cal_code_a: assert property ($past(!force_clear_bit && !bad) |-> dac_code ==
		cal($past(data_in), $past(gain_in), $past(offset_in))) else $error("calibrated code wrong");
	span_tab_a: assert property ({full_scale_span, range_min} == ($past(band_cfg_high) ?
		(active_range ? {DRC_SPAN_HN_MV, DRC_MIN_HN_MV} : {DRC_SPAN_HF_MV, DRC_MIN_HF_MV}) :
		(active_range ? {DRC_SPAN_LN_MV, DRC_MIN_LN_MV} : {DRC_SPAN_LF_MV, DRC_MIN_LF_MV})))
		else $error("span or minimum wrong");
	analog_output_a: assert property (analog_output == 13'(((32'($past(dac_code))
		* 32'($past(full_scale_span))) >> N) + 32'($past(range_min)))) else $error("output mv wrong");
endmodule : drc_mon
bind drc_top drc_mon #(.N(N)) drc_mon_i (.*);

// file: tb/testbench.sv
// testbench: random host writes checked against a reference of range, band and code
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import drc_pkg::*;
	typedef struct packed {logic rs, cs, fc; logic [15:0] d, g, o, cv; logic [1:0] ar;
		logic [12:0] ms; logic bh;} drc_cfg_t;
	typedef struct packed {logic rng, clr, alm; drc_band_t band; logic [15:0] code;
		logic [12:0] sp, mn;} drc_exp_t;
	`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
		$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
	logic core_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, active_range, in_clear, supply_alarm;
	logic [1:0] wr_d = 2'h0;
	drc_cfg_t wc = '0, hc;
	drc_exp_t q[$], ex;
	drc_band_t supply_band;
	logic [15:0] dac_code, code_ff = 16'h0;
	logic [12:0] full_scale_span, range_min, analog_output;
	logic [12:0] sup[8] = '{13'h06AE, 13'h0762, 13'h06AD, 13'h0763,
		13'h0A8C, 13'h157C, 13'h0A8B, 13'h157D};
	int num_errors = 0, n_tests = 0;
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) wr_d <= {wr_d[0], wr};
	drc_host #(.W($bits(drc_cfg_t))) drc_host_i (.core_clk, .rst_n, .wr, .wr_cfg(wc), .cfg_ff(hc));
	drc_top #(.N(16)) drc_top_i (.core_clk, .rst_n, .range_sel(hc.rs), .clear_span_select(hc.cs),
		.force_clear_bit(hc.fc), .data_in(hc.d), .gain_in(hc.g), .offset_in(hc.o),
		.clear_value_reg(hc.cv), .alarm_response_reg(hc.ar), .main_supply(hc.ms),
		.band_cfg_high(hc.bh), .active_range, .in_clear, .supply_band, .supply_alarm, .dac_code,
		.full_scale_span, .range_min, .analog_output);
	// ==========================================
	// reference: alarm hold, zero and full outrank clear and data
	function automatic drc_exp_t model(input drc_cfg_t c, input logic [15:0] prev);
		drc_exp_t e;
		longint p;
		logic lo, hi;
		lo = c.ms >= 13'h06AE && c.ms <= 13'h0762;
		hi = c.ms >= 13'h0A8C && c.ms <= 13'h157C;
		e.band = hi ? DRC_BAND_HIGH : lo ? DRC_BAND_LOW : DRC_BAND_INVALID;
		e.alm = c.bh ? !hi : !lo;
		e.clr = c.fc || (e.alm && c.ar == DRC_ACT_CLEAR);
		e.rng = e.clr ? c.cs : c.rs;
		p = ((longint'(c.d) * (longint'(c.g) + 32768)) >>> 16) + longint'($signed(c.o));
		e.code = p < 0 ? 16'h0 : p > 65535 ? 16'hFFFF : p[15:0];
		if (e.clr) e.code = c.cv;
		if (e.alm && c.ar != DRC_ACT_CLEAR)
			e.code = c.ar == DRC_ACT_HOLD ? prev : c.ar == DRC_ACT_LOW ? 16'h0 : 16'hFFFF;
		case ({c.bh, e.rng})
			2'b00:   {e.sp, e.mn} = {DRC_SPAN_LF_MV, DRC_MIN_LF_MV};
			2'b01:   {e.sp, e.mn} = {DRC_SPAN_LN_MV, DRC_MIN_LN_MV};
			2'b10:   {e.sp, e.mn} = {DRC_SPAN_HF_MV, DRC_MIN_HF_MV};
			default: {e.sp, e.mn} = {DRC_SPAN_HN_MV, DRC_MIN_HN_MV};
		endcase
		return e;
	endfunction : model
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	// ==========================================
	// watcher: results land two edges after a write
	always @(negedge core_clk) begin
		if (wr_d[1]) begin
			ex = q.pop_front();
			`CHK("range", {ex.rng, ex.clr}, {active_range, in_clear})
			`CHK("band", {ex.band, ex.alm}, {supply_band, supply_alarm})
			`CHK("code", ex.code, dac_code)
			`CHK("span", {ex.sp, ex.mn}, {full_scale_span, range_min})
		end
	end
	initial begin
		drc_cfg_t c;
		logic w;
		void'($urandom(32'h89682EA2));
		repeat (12) @(posedge core_clk);
		`CHK("reset span", 13'h044C, full_scale_span)
		`CHK("reset analog_output", 13'h0096, analog_output)
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		$display("reset test done");
		for (int i = 0; i < 300; i++) begin
			c = $bits(drc_cfg_t)'({$urandom, $urandom, $urandom});
			if ($urandom_range(1) == 1) c.ms = sup[$urandom_range(7)];
			w = $urandom_range(3) != 0;
			wc <= c;
			wr <= w;
			if (w) begin
				ex = model(c, code_ff);
				code_ff = ex.code;
				q.push_back(ex);
			end
			@(posedge core_clk);
		end
		wr <= 1'b0;
		repeat (4) @(posedge core_clk);
		$display("random write test done");
		complete_run;
	end
	initial begin
		repeat (700) @(posedge core_clk);
		num_errors++;
		complete_run;
	end
endmodule : testbench
